// [core/dld_map.svh]
`ifndef DLD_MAP_SVH
`define DLD_MAP_SVH

// ************************
// register map (byte addresses)
// ************************
`define DLD_CTRL_ADDR 8'h00
`define DLD_STAT_ADDR 8'h04
`define DLD_CTRL_RST 32'h0000_0000

// ctrl field positions
`define DLD_CTRL_POLL_BIT 0

// status field positions
`define DLD_STAT_STATE_LSB 0
`define DLD_STAT_DTR_BIT 4
`define DLD_STAT_CONN_BIT 5

// ************************
// timing
// ************************
`define DLD_CLK_MHZ 125
`define DLD_CARRIER_WAIT_MS 9000
`define DLD_CARRIER_CYC (`DLD_CARRIER_WAIT_MS * 1000 * `DLD_CLK_MHZ)
`define DLD_SETTLE_MS 1000
`define DLD_SETTLE_CYC (`DLD_SETTLE_MS * 1000 * `DLD_CLK_MHZ)
`define DLD_FLASH_MS 250
`define DLD_FLASH_CYC (`DLD_FLASH_MS * 1000 * `DLD_CLK_MHZ)

// baud divisors: clock cycles per bit, rounded down
`define DLD_BAUD_1200 1200
`define DLD_BAUD_300 300
`define DLD_BAUD_150 150
`define DLD_BAUD_110 110
`define DLD_DIV_1200 (`DLD_CLK_MHZ * 1000000 / `DLD_BAUD_1200)
`define DLD_DIV_300 (`DLD_CLK_MHZ * 1000000 / `DLD_BAUD_300)
`define DLD_DIV_150 (`DLD_CLK_MHZ * 1000000 / `DLD_BAUD_150)
`define DLD_DIV_110 (`DLD_CLK_MHZ * 1000000 / `DLD_BAUD_110)

`endif

// [core/dld_pkg.sv]
package dld_pkg;

    // three-position selector codes
    typedef enum logic [1:0] {
        DLD_POS_LEFT = 2'b00,
        DLD_POS_CENTRE = 2'b01,
        DLD_POS_RIGHT = 2'b10
    } dld_pos_t;

    // gray codes along check -> wait -> carrier -> settle -> connected
    typedef enum logic [3:0] {
        DLD_IDLE = 4'b0000,
        DLD_LINE_CHECK_STATE = 4'b0001,
        DLD_WAIT_FOR_CALL_STATE = 4'b0011,
        DLD_CARRIER_WAIT = 4'b0010,
        DLD_LINE_SETTLE_STATE = 4'b0110,
        DLD_CONNECTED = 4'b0111,
        DLD_LINE_BYPASS_STATE = 4'b0101,
        DLD_POLL_STATE = 4'b0100
    } dld_state_t;

    typedef enum logic [1:0] {
        DLD_PAR_ODD = 2'b00,
        DLD_PAR_MARK = 2'b01,
        DLD_PAR_EVEN = 2'b10
    } dld_parity_t;

    typedef struct packed {
        logic on_line;
        logic high_rate_select;
        dld_pos_t speed;
        dld_pos_t parity;
        dld_pos_t protocol;
        logic half_duplex;
        logic remote_device_control;
    } dld_panel_t;

    typedef struct packed {
        logic dsr;
        logic dcd;
        logic ri;
    } dld_eia_in_t;

    typedef struct packed {
        logic ring_lamp;
        logic ready_lamp;
        logic tx_lamp;
        logic rx_lamp;
    } dld_lamps_t;

endpackage

// [core/dld_line_ctrl.sv]
`timescale 1ns/1ps
`include "dld_map.svh"
// Function
// - off-line switch holds idle, line inhibited
// - on-line enters check; centred protocol bypasses
// - bypass state asserts DTR
// - bypass until switch off, then idle
// - config bit picks auto-answer or polling
// - auto-answer check: DTR low until DSR low
// - DSR low: wait-for-call, assert DTR
// - high rate switch gives 1200 baud
// - speed selector gives 110, 150, 300
// - parity selector gives odd, mark, even
// - protocol left blocked, right nonblocked
// - half duplex echoes nonblocked sends locally
// - line half duplex; blocked needs full
// - remote control only while switch on
// - ring lamp flashes; ready lamp when on-line
// - direction lamps only after call answered; also lit in bypass and poll
// - blocked: char parity plus block LRC
// - low rate: carrier within timeout else drop
// - settle dwell before connected state
module dld_line_ctrl
    import dld_pkg::*;
#(
    parameter int unsigned CARRIER_CYC = `DLD_CARRIER_CYC,
    parameter int unsigned SETTLE_CYC = `DLD_SETTLE_CYC,
    parameter int unsigned FLASH_CYC = `DLD_FLASH_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire dld_panel_t panel,
    input wire dld_eia_in_t eia_in,
    output logic dtr,
    output dld_lamps_t lamps,
    output logic line_enable,
    output logic blocked_mode,
    output logic [31:0] baud_div,
    output dld_parity_t tx_parity,
    output logic local_echo,
    output logic rdc_enable,
    input wire logic [7:0] tx_char,
    input wire logic tx_char_valid,
    input wire logic tx_block_end,
    input wire logic tx_active,
    output logic [7:0] tx_char_par,
    output logic [7:0] block_lrc,
    output logic block_lrc_valid,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ************************
    // input synchronisers
    // ************************
    localparam int SYNC_W = $bits(dld_panel_t) + $bits(dld_eia_in_t);
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    dld_panel_t pnl;
    dld_eia_in_t eia;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {panel, eia_in};
            sync2_ff <= sync1_ff;
        end
    end
    assign {pnl, eia} = sync2_ff;

    // ************************
    // register bus
    // ************************
    logic [31:0] ctrl_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    dld_state_t state_ff;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
            ctrl_ff <= `DLD_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (aw_got_ff && w_got_ff) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                if (awaddr_ff == `DLD_CTRL_ADDR) begin
                    bresp_ff <= 2'b00;
                    if (wstrb_ff[0]) begin
                        ctrl_ff[7:0] <= wdata_ff[7:0];
                    end
                end else if (awaddr_ff == `DLD_STAT_ADDR) begin
                    bresp_ff <= 2'b00;
                end else begin
                    bresp_ff <= 2'b10;
                end
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= 2'b00;
            rdata_ff <= 32'h0000_0000;
            case (s_axi_araddr)
                `DLD_CTRL_ADDR: begin
                    rdata_ff <= ctrl_ff;
                end
                `DLD_STAT_ADDR: begin
                    rdata_ff[`DLD_STAT_STATE_LSB +: 4] <= state_ff;
                    rdata_ff[`DLD_STAT_DTR_BIT] <= dtr;
                    rdata_ff[`DLD_STAT_CONN_BIT] <= (state_ff == DLD_CONNECTED);
                end
                default: begin
                    rresp_ff <= 2'b10;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ************************
    // line discipline state machine
    // ************************
    dld_state_t nxt_state;
    logic [31:0] timer_ff;
    logic poll_sel;
    logic timer_done;

    assign poll_sel = ctrl_ff[`DLD_CTRL_POLL_BIT];

    always_comb begin
        nxt_state = state_ff;
        if (!pnl.on_line) begin
            nxt_state = DLD_IDLE;
        end else begin
            case (state_ff)
                DLD_IDLE: begin
                    nxt_state = DLD_LINE_CHECK_STATE;
                end
                DLD_LINE_CHECK_STATE: begin
                    if (pnl.protocol == DLD_POS_CENTRE) begin
                        nxt_state = DLD_LINE_BYPASS_STATE;
                    end else if (poll_sel) begin
                        nxt_state = DLD_POLL_STATE;
                    end else if (!eia.dsr) begin
                        nxt_state = DLD_WAIT_FOR_CALL_STATE;
                    end
                end
                DLD_WAIT_FOR_CALL_STATE: begin
                    // modem raises DSR after its answer tone
                    if (eia.dsr) begin
                        nxt_state = pnl.high_rate_select ? DLD_LINE_SETTLE_STATE
                                                         : DLD_CARRIER_WAIT;
                    end
                end
                DLD_CARRIER_WAIT: begin
                    if (eia.dcd) begin
                        nxt_state = DLD_LINE_SETTLE_STATE;
                    end else if (timer_done) begin
                        nxt_state = DLD_IDLE;
                    end
                end
                DLD_LINE_SETTLE_STATE: begin
                    if (timer_done) begin
                        nxt_state = DLD_CONNECTED;
                    end
                end
                DLD_CONNECTED: begin
                    if (!eia.dsr) begin
                        nxt_state = DLD_IDLE;
                    end
                end
                DLD_LINE_BYPASS_STATE: begin
                    nxt_state = DLD_LINE_BYPASS_STATE;
                end
                DLD_POLL_STATE: begin
                    nxt_state = DLD_POLL_STATE;
                end
                default: begin
                    nxt_state = DLD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= DLD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // one timer serves carrier wait and settle; reload on every state change
    assign timer_done = (state_ff == DLD_CARRIER_WAIT) ? (timer_ff >= CARRIER_CYC - 1)
                                                       : (timer_ff >= SETTLE_CYC - 1);

    always_ff @(posedge clock) begin
        if (sys_rst || nxt_state != state_ff) begin
            timer_ff <= 32'h0000_0000;
        end else begin
            timer_ff <= timer_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dtr <= 1'b0;
        end else begin
            case (nxt_state)
                DLD_LINE_BYPASS_STATE,
                DLD_WAIT_FOR_CALL_STATE,
                DLD_CARRIER_WAIT,
                DLD_LINE_SETTLE_STATE,
                DLD_CONNECTED,
                DLD_POLL_STATE: begin
                    dtr <= 1'b1;
                end
                default: begin
                    dtr <= 1'b0;
                end
            endcase
        end
    end

    // ************************
    // line configuration
    // ************************
    logic connected;
    assign connected = (state_ff == DLD_CONNECTED) || (state_ff == DLD_LINE_BYPASS_STATE)
                     || (state_ff == DLD_POLL_STATE);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            line_enable <= 1'b0;
            blocked_mode <= 1'b0;
            baud_div <= 32'h0000_0000;
            tx_parity <= DLD_PAR_ODD;
            local_echo <= 1'b0;
            rdc_enable <= 1'b0;
        end else begin
            line_enable <= connected;
            // blocked only with full duplex; bypass is always nonblocked
            blocked_mode <= (pnl.protocol == DLD_POS_LEFT) && !pnl.half_duplex
                            && (state_ff != DLD_LINE_BYPASS_STATE);
            if (pnl.high_rate_select) begin
                baud_div <= `DLD_DIV_1200;
            end else begin
                case (pnl.speed)
                    DLD_POS_LEFT: baud_div <= `DLD_DIV_110;
                    DLD_POS_CENTRE: baud_div <= `DLD_DIV_150;
                    default: baud_div <= `DLD_DIV_300;
                endcase
            end
            case (pnl.parity)
                DLD_POS_LEFT: tx_parity <= DLD_PAR_ODD;
                DLD_POS_CENTRE: tx_parity <= DLD_PAR_MARK;
                default: tx_parity <= DLD_PAR_EVEN;
            endcase
            local_echo <= pnl.half_duplex && (pnl.protocol != DLD_POS_LEFT);
            rdc_enable <= pnl.remote_device_control && connected;
        end
    end

    // ************************
    // character parity and block check
    // ************************
    logic par_bit;
    always_comb begin
        case (tx_parity)
            DLD_PAR_ODD: par_bit = ~^tx_char[6:0];
            DLD_PAR_MARK: par_bit = 1'b1;
            default: par_bit = ^tx_char[6:0];
        endcase
    end

    logic [7:0] lrc_acc_ff;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_char_par <= 8'h00;
            lrc_acc_ff <= 8'h00;
            block_lrc <= 8'h00;
            block_lrc_valid <= 1'b0;
        end else begin
            block_lrc_valid <= 1'b0;
            if (tx_char_valid) begin
                tx_char_par <= {par_bit, tx_char[6:0]};
                if (blocked_mode) begin
                    if (tx_block_end) begin
                        block_lrc <= lrc_acc_ff ^ {par_bit, tx_char[6:0]};
                        block_lrc_valid <= 1'b1;
                        lrc_acc_ff <= 8'h00;
                    end else begin
                        lrc_acc_ff <= lrc_acc_ff ^ {par_bit, tx_char[6:0]};
                    end
                end
            end
        end
    end

    // ************************
    // lamps
    // ************************
    logic [31:0] flash_cnt_ff;
    logic flash_ff;
    always_ff @(posedge clock) begin
        if (sys_rst || !eia.ri) begin
            flash_cnt_ff <= 32'h0000_0000;
            flash_ff <= 1'b0;
        end else if (flash_cnt_ff >= FLASH_CYC - 1) begin
            flash_cnt_ff <= 32'h0000_0000;
            flash_ff <= !flash_ff;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lamps <= '0;
        end else begin
            lamps.ring_lamp <= eia.ri && !flash_ff;
            lamps.ready_lamp <= pnl.on_line;
            // half duplex line: exactly one direction lamp once answered
            lamps.tx_lamp <= connected && tx_active;
            lamps.rx_lamp <= connected && !tx_active;
        end
    end

    // ************************
    // checks
    // ************************
    property p_offline_idle;
        @(posedge clock) disable iff (sys_rst)
        !sync2_ff[SYNC_W-1] |=> state_ff == DLD_IDLE;
    endproperty
    a_offline_idle: assert property (p_offline_idle) else $error("not idle off-line");

    property p_bypass_dtr;
        @(posedge clock) disable iff (sys_rst)
        state_ff == DLD_LINE_BYPASS_STATE |-> dtr;
    endproperty
    a_bypass_dtr: assert property (p_bypass_dtr) else $error("bypass without dtr");

    property p_check_no_dtr;
        @(posedge clock) disable iff (sys_rst)
        state_ff == DLD_LINE_CHECK_STATE |-> !dtr;
    endproperty
    a_check_no_dtr: assert property (p_check_no_dtr) else $error("dtr in check");

    property p_hi_rate;
        @(posedge clock) disable iff (sys_rst)
        pnl.high_rate_select |=> baud_div == `DLD_DIV_1200;
    endproperty
    a_hi_rate: assert property (p_hi_rate) else $error("wrong high rate");

    property p_rdc;
        @(posedge clock) disable iff (sys_rst)
        !pnl.remote_device_control |=> !rdc_enable;
    endproperty
    a_rdc: assert property (p_rdc) else $error("rdc while off");

    property p_dir_lamps;
        @(posedge clock) disable iff (sys_rst)
        !$past(connected) |-> !lamps.tx_lamp && !lamps.rx_lamp;
    endproperty
    a_dir_lamps: assert property (p_dir_lamps) else $error("lamp before answer");

    property p_blocked_full;
        @(posedge clock) disable iff (sys_rst)
        blocked_mode |-> !$past(pnl.half_duplex);
    endproperty
    a_blocked_full: assert property (p_blocked_full) else $error("blocked in half");

    property p_settle;
        @(posedge clock) disable iff (sys_rst)
        state_ff == DLD_CONNECTED && $past(state_ff) != DLD_CONNECTED
            |-> $past(state_ff) == DLD_LINE_SETTLE_STATE;
    endproperty
    a_settle: assert property (p_settle) else $error("skipped settle");

endmodule

// [verification/dld_modem_model.sv]
`timescale 1ns/1ps
// ************************
// modem on the far side of the EIA lines
// ************************
module dld_modem_model
    import dld_pkg::*;
#(
    parameter int TONE_CYC = 30
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic dtr,
    input wire logic ring,
    input wire logic hang_up,
    input wire logic carrier_ok,
    output dld_eia_in_t eia_in
);
    logic dsr_ff;
    logic dtr_ff;
    int tone_ff;
    // a prior call is still up after reset, so the device must first see it clear
    always_ff @(posedge clock) begin
        dtr_ff <= dtr;
        if (sys_rst) begin
            dsr_ff <= 1'b1;
            tone_ff <= 0;
        end else if (hang_up || (dtr_ff && !dtr)) begin
            dsr_ff <= 1'b0;
            tone_ff <= 0;
        end else if (ring && dtr && !dsr_ff) begin
            tone_ff <= tone_ff + 1;
            if (tone_ff == TONE_CYC) dsr_ff <= 1'b1;
        end
    end
    assign eia_in = '{dsr: dsr_ff, dcd: dsr_ff && carrier_ok, ri: ring};
endmodule

// [verification/dialup_line_discipline_bench.sv]
`timescale 1ns/1ps
`include "dld_map.svh"
module dialup_line_discipline_bench import dld_pkg::*;;
    // ************************
    // stimulus and design
    // ************************
    localparam logic [33:0] ALL = 34'h3_FFFF_FFFF;
    localparam logic [33:0] ST6 = 34'h3_0000_003F;
    localparam logic [33:0] ST5 = 34'h3_0000_001F;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    dld_panel_t pnl = '0;
    dld_eia_in_t eia;
    dld_lamps_t lamps;
    dld_parity_t tx_parity;
    logic ring = 1'b0, hang = 1'b0, car = 1'b0, vd = 1'b0, dtr_q = 1'b0;
    logic dtr, line_enable, blocked_mode, local_echo, rdc_enable, block_lrc_valid;
    logic [31:0] baud_div, rdat, s_axi_rdata;
    logic [7:0] tx_char = '0, tx_char_par, block_lrc, lrc = '0;
    logic tx_char_valid = 1'b0, tx_block_end = 1'b0, tx_active = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] q_val[$], q_msk[$];
    logic [7:0] q_chr[$], q_lrc[$];
    integer seed = 32'h8b8a61c6;
    int mismatches = 0, num_checks = 0, cyc = 0, n_fall = 0, i, f0;

    always #4 clock = ~clock;

    dld_line_ctrl #(.CARRIER_CYC(20), .SETTLE_CYC(10), .FLASH_CYC(4)) dld_line_ctrl_inst (
        .clock(clock), .sys_rst(sys_rst), .panel(pnl), .eia_in(eia), .dtr(dtr),
        .lamps(lamps), .line_enable(line_enable), .blocked_mode(blocked_mode),
        .baud_div(baud_div), .tx_parity(tx_parity), .local_echo(local_echo),
        .rdc_enable(rdc_enable), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
        .tx_block_end(tx_block_end), .tx_active(tx_active), .tx_char_par(tx_char_par),
        .block_lrc(block_lrc), .block_lrc_valid(block_lrc_valid),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    dld_modem_model dld_modem_model_inst (.clock(clock), .sys_rst(sys_rst), .dtr(dtr),
        .ring(ring), .hang_up(hang), .carrier_ok(car), .eia_in(eia));

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    function automatic logic [7:0] par(input logic [7:0] c);
        case (pnl.parity)
            DLD_POS_LEFT: return {~^c[6:0], c[6:0]};
            DLD_POS_CENTRE: return {1'b1, c[6:0]};
            default: return {^c[6:0], c[6:0]};
        endcase
    endfunction

    function automatic logic [33:0] st(input dld_state_t s, input logic d, input logic c);
        return {28'h000_0000, c, d, s};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        q_val.push_back({r, 32'h0000_0000});
        q_msk.push_back(ALL);
        do begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        q_val.push_back(e);
        q_msk.push_back(m);
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask

    task automatic ws(input dld_state_t s);
        int n;
        n = 0;
        do begin
            rd(`DLD_STAT_ADDR, '0, '0);
            n++;
        end while (rdat[3:0] !== s && n < 100);
    endtask

    task automatic send(input logic last);
        logic [7:0] c;
        c = 8'($random(seed)) & 8'h7F;
        @(posedge clock);
        tx_char <= c;
        tx_char_valid <= 1'b1;
        tx_block_end <= last;
        q_chr.push_back(par(c));
        lrc = lrc ^ par(c);
        if (last) q_lrc.push_back(lrc);
        if (last) lrc = '0;
        @(posedge clock);
        tx_char_valid <= 1'b0;
        tx_block_end <= 1'b0;
    endtask

    task automatic pause();
        repeat (6) @(posedge clock);
    endtask

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask

    // ************************
    // result watcher
    // ************************
    task automatic pop(input logic [33:0] g);
        logic [33:0] e, m;
        e = q_val.pop_front();
        m = q_msk.pop_front();
        if (m !== 34'h0_0000_0000) chk(g & m, e & m);
    endtask

    always @(posedge clock) begin
        vd <= tx_char_valid;
        dtr_q <= dtr;
        if (dtr_q && !dtr) n_fall++;
        if (s_axi_rvalid && s_axi_rready) pop({s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) pop({s_axi_bresp, 32'h0000_0000});
        if (vd) chk(34'(tx_char_par), 34'(q_chr.pop_front()));
        if (block_lrc_valid)
            chk(34'(block_lrc), (q_lrc.size() > 0) ? 34'(q_lrc.pop_front()) : ALL);
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk(34'({dtr, line_enable, lamps}), '0);
        rd(`DLD_CTRL_ADDR, '0, ALL);
        rd(8'h08, {2'b10, 32'h0000_0000}, ALL);
        wr(8'h0C, '0, 2'b10);
        tend("reset");
        wr(`DLD_CTRL_ADDR, '0, 2'b00);
        @(posedge clock);
        pnl.on_line <= 1'b1;
        pnl.protocol <= DLD_POS_RIGHT;
        pause();
        rd(`DLD_STAT_ADDR, st(DLD_LINE_CHECK_STATE, 0, 0), ST6);
        chk(34'(lamps.ready_lamp), 34'h1);
        hang <= 1'b1;
        @(posedge clock);
        hang <= 1'b0;
        tx_active <= 1'b1;
        ws(DLD_WAIT_FOR_CALL_STATE);
        rd(`DLD_STAT_ADDR, st(DLD_WAIT_FOR_CALL_STATE, 1, 0), ST6);
        chk(34'({lamps.tx_lamp, lamps.rx_lamp}), '0);
        ring <= 1'b1;
        for (i = 0; i < 40 && lamps.ring_lamp !== 1'b1; i++) @(posedge clock);
        chk(34'(lamps.ring_lamp), 34'h1);
        for (i = 0; i < 40 && lamps.ring_lamp !== 1'b0; i++) @(posedge clock);
        chk(34'(lamps.ring_lamp), 34'h0);
        f0 = n_fall;
        ws(DLD_CARRIER_WAIT);
        ring <= 1'b0;
        rd(`DLD_STAT_ADDR, st(DLD_CARRIER_WAIT, 1, 0), ST6);
        ws(DLD_WAIT_FOR_CALL_STATE);
        chk(34'(n_fall > f0), 34'h1);
        pnl.high_rate_select <= 1'b1;
        ring <= 1'b1;
        ws(DLD_LINE_SETTLE_STATE);
        ring <= 1'b0;
        rd(`DLD_STAT_ADDR, st(DLD_LINE_SETTLE_STATE, 1, 0), ST6);
        ws(DLD_CONNECTED);
        rd(`DLD_STAT_ADDR, st(DLD_CONNECTED, 1, 1), ST6);
        chk(34'({line_enable, lamps.tx_lamp, lamps.rx_lamp}), 34'h6);
        tx_active <= 1'b0;
        pause();
        chk(34'({lamps.tx_lamp, lamps.rx_lamp}), 34'h1);
        f0 = n_fall;
        hang <= 1'b1;
        @(posedge clock);
        hang <= 1'b0;
        ws(DLD_WAIT_FOR_CALL_STATE);
        chk(34'(n_fall > f0), 34'h1);
        pnl.on_line <= 1'b0;
        ws(DLD_IDLE);
        rd(`DLD_STAT_ADDR, st(DLD_IDLE, 0, 0), ST6);
        tend("answer");
        pnl.on_line <= 1'b1;
        pnl.protocol <= DLD_POS_CENTRE;
        pnl.high_rate_select <= 1'b0;
        ws(DLD_LINE_BYPASS_STATE);
        rd(`DLD_STAT_ADDR, st(DLD_LINE_BYPASS_STATE, 1, 0), ST5);
        chk(34'({line_enable, blocked_mode}), 34'h2);
        for (i = 0; i < 3; i++) begin
            pnl.speed <= dld_pos_t'(i);
            pnl.parity <= dld_pos_t'(i);
            pnl.half_duplex <= i[0];
            pnl.remote_device_control <= i[0];
            pause();
            chk(34'(baud_div), (i == 0) ? `DLD_DIV_110 : (i == 1) ? `DLD_DIV_150 : `DLD_DIV_300);
            chk(34'(tx_parity), 34'(i));
            chk(34'({local_echo, rdc_enable}), {32'h0, i[0], i[0]});
            send(1'b0);
        end
        pnl.high_rate_select <= 1'b1;
        pause();
        chk(34'(baud_div), `DLD_DIV_1200);
        pnl.on_line <= 1'b0;
        ws(DLD_IDLE);
        rd(`DLD_STAT_ADDR, st(DLD_IDLE, 0, 0), ST6);
        tend("bypass");
        wr(`DLD_CTRL_ADDR, 32'h0000_0001, 2'b00);
        rd(`DLD_CTRL_ADDR, {2'b00, 32'h0000_0001}, ALL);
        @(posedge clock);
        pnl.protocol <= DLD_POS_LEFT;
        pnl.half_duplex <= 1'b0;
        pnl.parity <= DLD_POS_RIGHT;
        lrc = '0;
        pnl.on_line <= 1'b1;
        ws(DLD_POLL_STATE);
        rd(`DLD_STAT_ADDR, st(DLD_POLL_STATE, 1, 0), ST5);
        chk(34'(blocked_mode), 34'h1);
        send(1'b0);
        send(1'b0);
        send(1'b1);
        pnl.half_duplex <= 1'b1;
        pause();
        chk(34'(blocked_mode), 34'h0);
        tend("poll");
        test_done();
    end
endmodule
